// ### core/irq_flag_bank.sv
// sticky event flags with clear-on-read, set winning over clear
`timescale 1ns/1ps
module irq_flag_bank
    import phy_irq_pkg::*;
#(
    parameter int W = REG_W,
    parameter logic [W-1:0] IMPL = FLAG_IMPL_MASK
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    irq_flag_if.bank port
);

    logic [W-1:0] flags;
    logic [W-1:0] next_flags;

    // ------------------------------------------------------------------
    // per-bit latch
    // ------------------------------------------------------------------
    generate
        for (genvar b = 0; b < W; b++) begin : g_flag
            if (IMPL[b]) begin : g_impl
                assign next_flags[b] = port.event_in[b] | (flags[b] & ~port.clear[b]);
            end else begin : g_rsvd
                assign next_flags[b] = 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flags <= IRQ_FLAG_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    assign port.flags = flags;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_FLAG_SETS: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (|(port.event_in & IMPL)) |=>
            ((flags & $past(port.event_in & IMPL)) == $past(port.event_in & IMPL)))
    else $error("event did not latch its flag");

    AST_FLAG_CLEARS: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (|(port.clear & ~port.event_in)) |=>
            ((flags & $past(port.clear & ~port.event_in)) == '0))
    else $error("cleared flag without event stayed set");

    AST_SET_WINS: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (|(port.clear & port.event_in & IMPL)) |=>
            ((flags & $past(port.clear & port.event_in & IMPL))
                == $past(port.clear & port.event_in & IMPL)))
    else $error("event lost to a simultaneous clear");

    AST_RSVD_ZERO: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (flags & ~IMPL) == '0)
    else $error("reserved flag bit set");

endmodule

// ### core/phy_interrupt_enable_status.sv
// interrupt enable mask, event flags and management read path of the phy
//
// Function
// - mask bit 15 gates autoneg fault
// - mask bits 14, 13: rate, duplex change
// - mask bits 12, 11: page, link fail
// - mask bit 10 gates link up
// - mask bits 6, 5: wake, rate downgrade
// - mask bits 1, 0: polarity, babble
// - mask resets zero; reserved fields stay writable
// - flag 15 latches autoneg fault, read clears
// - flags 14, 13 latch rate, duplex change
// - flags 12, 11 latch page, link fail
// - flag 10 latches link up, read clears
// - flags 6, 5 latch wake, downgrade
// - flags 1, 0 polarity, babble; reserved zero
// - latched read captures word at start
`timescale 1ns/1ps
module phy_interrupt_enable_status
    import phy_irq_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_autoneg_fault,
    input wire logic i_rate_change,
    input wire logic i_duplex_change,
    input wire logic i_page_received,
    input wire logic i_link_fail,
    input wire logic i_link_up,
    input wire logic i_wake_event,
    input wire logic i_rate_downgrade,
    input wire logic i_polarity_flip,
    input wire logic i_babble,
    input wire logic [ADDR_W-1:0] i_mgmt_addr,
    input wire logic i_mgmt_wr,
    input wire logic [REG_W-1:0] i_mgmt_wdata,
    input wire logic i_mgmt_rd_start,
    input wire logic i_mgmt_rd_done,
    input wire logic i_read_latch_en,
    output logic [REG_W-1:0] o_mgmt_rdata,
    output logic o_irq
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    irq_flag_if #(.W(REG_W)) flag_bus ();

    logic [REG_W-1:0] events;
    logic [REG_W-1:0] irq_mask_reg;
    logic [REG_W-1:0] next_irq_mask_reg;
    logic [REG_W-1:0] irq_flag_reg;
    rd_state_e rd_state;
    rd_state_e next_rd_state;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] next_rd_addr;
    logic rd_latched;
    logic next_rd_latched;
    logic [REG_W-1:0] next_mgmt_rdata;
    logic [REG_W-1:0] rd_clear;
    logic [REG_W-1:0] live_value;
    logic next_irq;
    logic mask_written;

    function automatic logic [REG_W-1:0] reg_value(
        input logic [ADDR_W-1:0] addr,
        input logic [REG_W-1:0] mask,
        input logic [REG_W-1:0] flags
    );
        logic [REG_W-1:0] value;
        value = RDATA_UNMAPPED;
        case (addr)
            ADDR_IRQ_MASK_REG: value = mask;
            ADDR_IRQ_FLAG_REG: value = flags;
            default: value = RDATA_UNMAPPED;
        endcase
        return value;
    endfunction

    // ------------------------------------------------------------------
    // event flag bank
    // ------------------------------------------------------------------
    irq_flag_bank #(
        .W(REG_W),
        .IMPL(FLAG_IMPL_MASK)
    ) u_flag_bank (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .port(flag_bus.bank)
    );

    // detectors run on this clock, so their pulses enter unsynchronised
    always_comb begin
        events = IRQ_FLAG_RESET;
        events[BIT_AUTONEG_FAULT] = i_autoneg_fault;
        events[BIT_RATE_CHANGE] = i_rate_change;
        events[BIT_DUPLEX_CHANGE] = i_duplex_change;
        events[BIT_PAGE_RECEIVED] = i_page_received;
        events[BIT_LINK_FAIL] = i_link_fail;
        events[BIT_LINK_UP] = i_link_up;
        events[BIT_WAKE_EVENT] = i_wake_event;
        events[BIT_RATE_DOWNGRADE] = i_rate_downgrade;
        events[BIT_POLARITY_FLIP] = i_polarity_flip;
        events[BIT_BABBLE] = i_babble;
    end

    assign flag_bus.event_in = events;
    assign flag_bus.clear = rd_clear;
    assign irq_flag_reg = flag_bus.flags;

    // ------------------------------------------------------------------
    // enable mask register
    // ------------------------------------------------------------------
    always_comb begin
        next_irq_mask_reg = irq_mask_reg;
        // all sixteen bits writable, per-source enables
        if (i_mgmt_wr && (i_mgmt_addr == ADDR_IRQ_MASK_REG)) begin
            next_irq_mask_reg = i_mgmt_wdata;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_mask_reg <= IRQ_MASK_RESET;
        end else begin
            irq_mask_reg <= next_irq_mask_reg;
        end
    end

    // ------------------------------------------------------------------
    // management read path
    // ------------------------------------------------------------------
    assign live_value = reg_value(i_mgmt_addr, irq_mask_reg, irq_flag_reg);

    always_comb begin
        next_rd_state = rd_state;
        next_rd_addr = rd_addr;
        next_rd_latched = rd_latched;
        next_mgmt_rdata = o_mgmt_rdata;
        rd_clear = IRQ_FLAG_RESET;
        if (i_mgmt_rd_start) begin
            // a new start restarts any read still in progress
            next_rd_state = RD_HOLD;
            next_rd_addr = i_mgmt_addr;
            next_rd_latched = i_read_latch_en;
            next_mgmt_rdata = live_value;
            // latched word, flags cleared as captured
            if (i_read_latch_en && (i_mgmt_addr == ADDR_IRQ_FLAG_REG)) begin
                rd_clear = irq_flag_reg & FLAG_IMPL_MASK;
            end
        end else begin
            case (rd_state)
                RD_HOLD: begin
                    // unlatched reads track the register through the frame
                    if (!rd_latched) begin
                        next_mgmt_rdata = reg_value(rd_addr, irq_mask_reg, irq_flag_reg);
                    end
                    if (i_mgmt_rd_done) begin
                        next_rd_state = RD_IDLE;
                        // clear only what was shown, so later events survive
                        if (!rd_latched && (rd_addr == ADDR_IRQ_FLAG_REG)) begin
                            rd_clear = o_mgmt_rdata & FLAG_IMPL_MASK;
                        end
                    end
                end
                RD_IDLE: begin
                    next_rd_state = RD_IDLE;
                end
                default: begin
                    next_rd_state = RD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_state <= RD_IDLE;
            rd_addr <= ADDR_IRQ_MASK_REG;
            rd_latched <= 1'b0;
            o_mgmt_rdata <= RDATA_RESET;
        end else begin
            rd_state <= next_rd_state;
            rd_addr <= next_rd_addr;
            rd_latched <= next_rd_latched;
            o_mgmt_rdata <= next_mgmt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------------
    always_comb begin
        // any enabled flag drives the request
        next_irq = |(irq_flag_reg & irq_mask_reg);
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // helper: true once any write to the mask register has happened
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mask_written <= 1'b0;
        end else if (i_mgmt_wr && (i_mgmt_addr == ADDR_IRQ_MASK_REG)) begin
            mask_written <= 1'b1;
        end
    end

    AST_MASK_RESET_ZERO: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !mask_written |-> (irq_mask_reg == IRQ_MASK_RESET))
    else $error("mask not zero before first write");

    AST_MASK_WRITE: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_mgmt_wr && (i_mgmt_addr == ADDR_IRQ_MASK_REG)) |=>
            (irq_mask_reg == $past(i_mgmt_wdata)))
    else $error("mask write not stored");

    AST_MASK_HOLD: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !(i_mgmt_wr && (i_mgmt_addr == ADDR_IRQ_MASK_REG)) |=> $stable(irq_mask_reg))
    else $error("mask changed without write");

    AST_IRQ_FOLLOWS: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        1'b1 |=> (o_irq == $past(|(irq_flag_reg & irq_mask_reg))))
    else $error("interrupt output disagrees with enabled flags");

    AST_LATCH_CAPTURE: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_mgmt_rd_start && i_read_latch_en) |=>
            (o_mgmt_rdata == $past(live_value)) ##1
            ($stable(o_mgmt_rdata) || $past(i_mgmt_rd_start)))
    else $error("latched read word not captured or not held");

    AST_READ_CLEARS: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_mgmt_rd_start && i_read_latch_en && (i_mgmt_addr == ADDR_IRQ_FLAG_REG)
            && (events == IRQ_FLAG_RESET)) |=> (irq_flag_reg == IRQ_FLAG_RESET))
    else $error("flag read did not clear flags");

    AST_WRITE_FLAG_IGNORED: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_mgmt_wr && (i_mgmt_addr == ADDR_IRQ_FLAG_REG) && !i_mgmt_rd_start
            && (rd_state == RD_IDLE) && (events == IRQ_FLAG_RESET)) |=> $stable(irq_flag_reg))
    else $error("write altered read-only flags");

    AST_UNMAPPED_ZERO: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_mgmt_rd_start && (i_mgmt_addr != ADDR_IRQ_MASK_REG)
            && (i_mgmt_addr != ADDR_IRQ_FLAG_REG)) |=> (o_mgmt_rdata == RDATA_UNMAPPED))
    else $error("unmapped address returned data");

endmodule

// ### dv/mgmt_ctrl_model.sv
// management controller model that writes and reads the phy interrupt registers
`timescale 1ns/1ps
module mgmt_ctrl_model
    import phy_irq_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic [REG_W-1:0] i_rdata,
    output logic [ADDR_W-1:0] o_addr,
    output logic o_wr,
    output logic [REG_W-1:0] o_wdata,
    output logic o_rd_start,
    output logic o_rd_done,
    output logic o_latch_en
);
    initial begin
        o_addr = 5'h00;
        o_wr = 1'b0;
        o_wdata = 16'h0000;
        o_rd_start = 1'b0;
        o_rd_done = 1'b0;
        o_latch_en = 1'b1;
    end

    // ------------------------------------------------------------------
    // transfers
    // ------------------------------------------------------------------
    // tasks begin and end at a falling edge, so the phy never sees a change at its edge
    // a quiet cycle closes each transfer, so no line is assigned twice in one time step
    task automatic reg_write(input logic [ADDR_W-1:0] addr, input logic [REG_W-1:0] data);
        o_addr = addr;
        o_wdata = data;
        o_wr = 1'b1;
        @(negedge i_clk_sys);
        o_wr = 1'b0;
        // idle lines show no stale word
        o_wdata = ~data;
        o_addr = ~addr;
        @(negedge i_clk_sys);
    endtask

    // hold sets how long the read stays open before the done pulse; at least 1
    task automatic reg_read(input logic [ADDR_W-1:0] addr, input logic latch, input int hold,
                            output logic [REG_W-1:0] data);
        o_addr = addr;
        o_latch_en = latch;
        o_rd_start = 1'b1;
        @(negedge i_clk_sys);
        o_rd_start = 1'b0;
        repeat (hold) @(negedge i_clk_sys);
        data = i_rdata;
        o_rd_done = 1'b1;
        @(negedge i_clk_sys);
        o_rd_done = 1'b0;
        o_addr = ~addr;
        o_latch_en = 1'b1;
        @(negedge i_clk_sys);
    endtask
endmodule

// ### dv/phy_interrupt_enable_status_tb_top.sv
// self-checking bench for the phy interrupt enable mask and event flags
`timescale 1ns/1ps
module phy_interrupt_enable_status_tb_top;
    import phy_irq_pkg::*;
    typedef struct packed {
        logic [REG_W-1:0] mask;
        logic [REG_W-1:0] ev;
        logic irq;
    } row_s;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [REG_W-1:0] ev = 16'h0000;
    logic [ADDR_W-1:0] mgmt_addr;
    logic mgmt_wr;
    logic [REG_W-1:0] mgmt_wdata;
    logic rd_start;
    logic rd_done;
    logic latch_en;
    logic [REG_W-1:0] rdata;
    logic irq;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    row_s rows [14] = '{'{16'h8000, 16'h8000, 1'b1}, '{16'h4000, 16'h4000, 1'b1},
        '{16'h2000, 16'h2000, 1'b1}, '{16'h1000, 16'h1000, 1'b1}, '{16'h0800, 16'h0800, 1'b1},
        '{16'h0400, 16'h0400, 1'b1}, '{16'h0040, 16'h0040, 1'b1}, '{16'h0020, 16'h0020, 1'b1},
        '{16'h0002, 16'h0002, 1'b1}, '{16'h0001, 16'h0001, 1'b1}, '{16'h7fff, 16'h8000, 1'b0},
        '{16'h0001, 16'h0002, 1'b0}, '{16'hffff, 16'hfc63, 1'b1}, '{16'h0000, 16'hfc63, 1'b0}};

    always #4 clk_sys = ~clk_sys;

    phy_interrupt_enable_status phy_interrupt_enable_status_i (
        .i_clk_sys(clk_sys), .i_reset_n(reset_n),
        .i_autoneg_fault(ev[BIT_AUTONEG_FAULT]), .i_rate_change(ev[BIT_RATE_CHANGE]),
        .i_duplex_change(ev[BIT_DUPLEX_CHANGE]), .i_page_received(ev[BIT_PAGE_RECEIVED]),
        .i_link_fail(ev[BIT_LINK_FAIL]), .i_link_up(ev[BIT_LINK_UP]),
        .i_wake_event(ev[BIT_WAKE_EVENT]), .i_rate_downgrade(ev[BIT_RATE_DOWNGRADE]),
        .i_polarity_flip(ev[BIT_POLARITY_FLIP]), .i_babble(ev[BIT_BABBLE]),
        .i_mgmt_addr(mgmt_addr), .i_mgmt_wr(mgmt_wr), .i_mgmt_wdata(mgmt_wdata),
        .i_mgmt_rd_start(rd_start), .i_mgmt_rd_done(rd_done), .i_read_latch_en(latch_en),
        .o_mgmt_rdata(rdata), .o_irq(irq));

    mgmt_ctrl_model mgmt_ctrl_model_i (
        .i_clk_sys(clk_sys), .i_rdata(rdata), .o_addr(mgmt_addr), .o_wr(mgmt_wr),
        .o_wdata(mgmt_wdata), .o_rd_start(rd_start), .o_rd_done(rd_done),
        .o_latch_en(latch_en));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic lat, input logic [REG_W-1:0] exp);
        logic [REG_W-1:0] d;
        mgmt_ctrl_model_i.reg_read(a, lat, 1, d);
        check(d, exp);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] v);
        mgmt_ctrl_model_i.reg_write(a, v);
    endtask

    task automatic pulse(input logic [REG_W-1:0] v);
        ev = v;
        @(negedge clk_sys);
        ev = 16'h0000;
    endtask

    // the request lags its flag by one cycle, so two edges settle it
    task automatic irq_is(input logic e);
        repeat (2) @(negedge clk_sys);
        check({15'h0000, irq}, {15'h0000, e});
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        logic [REG_W-1:0] d;
        repeat (10) @(negedge clk_sys);
        reset_n = 1'b1;
        @(negedge clk_sys);
        rd(ADDR_IRQ_MASK_REG, 1'b1, 16'h0000);
        foreach (rows[k]) begin
            wr(ADDR_IRQ_MASK_REG, rows[k].mask);
            pulse(rows[k].ev);
            irq_is(rows[k].irq);
            rd(ADDR_IRQ_FLAG_REG, 1'b1, rows[k].ev & FLAG_IMPL_MASK);
            rd(ADDR_IRQ_FLAG_REG, 1'b1, 16'h0000);
            irq_is(1'b0);
        end
        $display("table rows done");
        wr(ADDR_IRQ_MASK_REG, 16'h039c);
        rd(ADDR_IRQ_MASK_REG, 1'b1, 16'h039c);
        wr(ADDR_IRQ_FLAG_REG, 16'hffff);
        rd(ADDR_IRQ_FLAG_REG, 1'b1, 16'h0000);
        rd(5'h05, 1'b1, 16'h0000);
        $display("access kinds done");
        // event stays high into the clearing read so both land on one edge
        ev = 16'h0001;
        @(negedge clk_sys);
        fork
            rd(ADDR_IRQ_FLAG_REG, 1'b1, 16'h0001);
            begin
                @(negedge clk_sys);
                ev = 16'h0000;
            end
        join
        rd(ADDR_IRQ_FLAG_REG, 1'b1, 16'h0001);
        rd(ADDR_IRQ_FLAG_REG, 1'b1, 16'h0000);
        $display("event during clearing read done");
        fork
            mgmt_ctrl_model_i.reg_read(ADDR_IRQ_FLAG_REG, 1'b1, 3, d);
            begin
                repeat (2) @(negedge clk_sys);
                pulse(16'h0020);
            end
        join
        check(d, 16'h0000);
        rd(ADDR_IRQ_FLAG_REG, 1'b1, 16'h0020);
        pulse(16'h0400);
        fork
            mgmt_ctrl_model_i.reg_read(ADDR_IRQ_FLAG_REG, 1'b0, 2, d);
            begin
                // lands with the done strobe, after the word was shown
                repeat (3) @(negedge clk_sys);
                pulse(16'h0020);
            end
        join
        check(d, 16'h0400);
        rd(ADDR_IRQ_FLAG_REG, 1'b1, 16'h0020);
        $display("latched and unlatched reads done");
        wr(ADDR_IRQ_MASK_REG, 16'h0000);
        pulse(16'h0002);
        irq_is(1'b0);
        wr(ADDR_IRQ_MASK_REG, 16'h0002);
        irq_is(1'b1);
        rd(ADDR_IRQ_FLAG_REG, 1'b1, 16'h0002);
        irq_is(1'b0);
        $display("late unmask done");
        wr(ADDR_IRQ_MASK_REG, 16'hffff);
        pulse(16'h8000);
        irq_is(1'b1);
        reset_n = 1'b0;
        @(negedge clk_sys);
        check({15'h0000, irq}, 16'h0000);
        reset_n = 1'b1;
        @(negedge clk_sys);
        rd(ADDR_IRQ_MASK_REG, 1'b1, 16'h0000);
        rd(ADDR_IRQ_FLAG_REG, 1'b1, 16'h0000);
        $display("mid-run reset done");
        tally_and_finish();
    end
endmodule

// ### pkg/irq_flag_if.sv
// carrier between the register front end and the event flag bank
`timescale 1ns/1ps
interface irq_flag_if #(parameter int W = 16);
    logic [W-1:0] event_in;
    logic [W-1:0] clear;
    logic [W-1:0] flags;

    modport bank (input event_in, input clear, output flags);
    modport ctrl (output event_in, output clear, input flags);
endinterface

// ### pkg/phy_irq_pkg.sv
// constants shared by the phy interrupt enable and event flag logic
package phy_irq_pkg;

    // ------------------------------------------------------------------
    // management register geometry
    // ------------------------------------------------------------------
    localparam int REG_W = 16;
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK_REG = 5'h12;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAG_REG = 5'h13;

    // ------------------------------------------------------------------
    // event bit positions, identical in mask and flag registers
    // ------------------------------------------------------------------
    localparam int BIT_AUTONEG_FAULT = 15;
    localparam int BIT_RATE_CHANGE = 14;
    localparam int BIT_DUPLEX_CHANGE = 13;
    localparam int BIT_PAGE_RECEIVED = 12;
    localparam int BIT_LINK_FAIL = 11;
    localparam int BIT_LINK_UP = 10;
    localparam int BIT_WAKE_EVENT = 6;
    localparam int BIT_RATE_DOWNGRADE = 5;
    localparam int BIT_POLARITY_FLIP = 1;
    localparam int BIT_BABBLE = 0;

    // flag bits that exist; bits 9:7 and 4:2 are reserved and read zero
    localparam logic [REG_W-1:0] FLAG_IMPL_MASK = 16'hfc63;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0] IRQ_MASK_RESET = 16'h0000;
    localparam logic [REG_W-1:0] IRQ_FLAG_RESET = 16'h0000;
    localparam logic [REG_W-1:0] RDATA_RESET = 16'h0000;
    localparam logic [REG_W-1:0] RDATA_UNMAPPED = 16'h0000;

    // ------------------------------------------------------------------
    // management read sequencing
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_HOLD = 1'b1
    } rd_state_e;

endpackage
